// file: inc/spnv_defs.svh
/*
 Constants of the serial nonvolatile memory engine: opcodes, address layout,
 protection bases, timing figures and identity fields.
 Assumes inclusion by bare name; definitions only.
*/
`ifndef SPNV_DEFS_SVH
`define SPNV_DEFS_SVH

// Opcodes sent by the bus master
`define SPNV_OP_SET_LATCH 8'h06
`define SPNV_OP_WRITE 8'h02
`define SPNV_OP_READ 8'h03
`define SPNV_OP_FAST 8'h0B
`define SPNV_OP_SLEEP 8'hB9
`define SPNV_OP_IDENT 8'h9F

// Array and protection layout
`define SPNV_AW 14
`define SPNV_WORDS 16384
`define SPNV_PROT_QTR 14'h3000
`define SPNV_PROT_HALF 14'h2000
`define SPNV_FIFO_DEPTH 8

// Timing: clock period and wake recovery, both in ns
`define SPNV_CLK_NS 4
`define SPNV_WAKE_NS 450000

// Identity string: nine bytes, low two hold the product fields
`define SPNV_ID_BYTES 9
`define SPNV_ID_FAMILY 3'h2
`define SPNV_ID_DENSITY 5'h03
`define SPNV_ID_SUB 2'h0
`define SPNV_ID_REV 3'h1

`endif

// file: inc/spnv_pkg.sv
/*
 Types shared by the memory engine, its write FIFO and their interface.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package spnv_pkg;
    typedef logic [13:0] spnv_addr_t;
    typedef struct packed {
        spnv_addr_t addr;
        logic [7:0] data;
    } spnv_wr_t;
    typedef enum logic [2:0] {
        ST_CMD, ST_ADDR, ST_DUMMY, ST_WDATA, ST_RDATA, ST_IDENT, ST_IGNORE
    } spnv_state_t;
    typedef enum logic [1:0] {OP_NONE, OP_WRITE, OP_READ, OP_FAST} spnv_op_t;
endpackage

// file: inc/spnv_wr_if.sv
/*
 Write path between the command engine, the FIFO and the array port.
 Assumes one clock shared by all parties.
*/
interface spnv_wr_if;
    import spnv_pkg::*;
    logic in_valid;
    logic in_ready;
    spnv_wr_t in_data;
    logic out_valid;
    logic out_ready;
    spnv_wr_t out_data;
    modport src (output in_valid, output in_data, input in_ready);
    modport buf_side (input in_valid, input in_data, output in_ready,
                      output out_valid, output out_data, input out_ready);
    modport sink (input out_valid, input out_data, output out_ready);
endinterface

// file: design/spnv_sync.sv
/*
 Two-stage synchroniser for a group of pin inputs.
 Assumes the inputs are asynchronous levels; the first stage feeds only the second.
*/
module spnv_sync #(
    parameter int N = 6
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [N-1:0] i_d,
    output logic [N-1:0] o_q
);
    logic [N-1:0] meta;

    // One pair of flops per bit; idle-high reset suits the active-low pins
    for (genvar g = 0; g < N; g++) begin : g_bit
        always_ff @(posedge i_clk) begin
            if (i_rst) begin
                meta[g] <= 1'b1;
                o_q[g] <= 1'b1;
            end else begin
                meta[g] <= i_d[g];
                o_q[g] <= meta[g];
            end
        end
    end
endmodule

// file: design/spnv_fifo.sv
/*
 Small FIFO holding received write bytes until the array port is free.
 Assumes a single clock; the drain side may stall through out_ready.
*/
module spnv_fifo #(
    parameter int W = 22,
    parameter int D = 8
) (
    input wire logic i_clk,
    input wire logic i_rst,
    spnv_wr_if.buf_side f
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW:0] wp;
    logic [AW:0] rp;
    wire [AW:0] used = wp - rp;
    wire push = f.in_valid & f.in_ready;
    wire pop = f.out_valid & f.out_ready;

    // Full and empty come straight from the pointer distance
    assign f.in_ready = (used != (AW+1)'(D));
    assign f.out_valid = (used != '0);
    assign f.out_data = mem[rp[AW-1:0]];

    // Pointer update
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            wp <= '0;
            rp <= '0;
        end else begin
            wp <= wp + (AW+1)'(push);
            rp <= rp + (AW+1)'(pop);
        end
    end

    // Storage, no reset needed
    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[wp[AW-1:0]] <= f.in_data;
        end
    end
endmodule

// file: design/spnv_core.sv
/*
 Slave command engine of a 16K x 8 serial nonvolatile memory on an SPI bus,
 modes 0 and 3: burst write, read, fast read, hold, sleep and identity.
 Assumes all pins are asynchronous to i_clk and are sampled here; the serial
 clock must be slow enough for several i_clk cycles per half period.
*/
// Notes on behaviour
// - Two address bytes follow, MSB first; low 14 bits used, top two ignored.
// - Address increments after each byte and wraps from top to zero.
// - Data bytes move most significant bit first in both directions.
// - Chip select high ends a write burst; nothing more is stored.
// - Reaching a protected address stops increment and drops the rest of the burst.
// - Each byte commits once its eighth bit arrives; no page limit.
// - A partially shifted final byte is never committed.
// - Read data starts on the clock after the last address bit; input ignored.
// - Chip select high ends a read and floats the output.
// - Fast read takes one dummy byte after address, then streams like read.
// - Fast read ignores input; chip select high ends it and floats output.
// - Hold low pauses the transfer; hold high resumes it at the same point.
// - Sleep entered when sleep opcode is in and chip select rises.
// - Asleep: clock and input ignored, output floats, chip select still watched.
// - Chip select fall wakes it within recovery time; frames ignored meanwhile.
// - Identity opcode returns manufacturer code then product code.
// - Identity is nine bytes: 56-bit manufacturer part, two field-packed product bytes.
// - Opcodes: latch-set 06h, write 02h, read 03h.
// - Chip select rise after a write frame clears the write latch.
// - Protect bits choose none, from 3000h, from 2000h, or the whole array.
`include "spnv_defs.svh"

module spnv_core #(
    parameter int unsigned WAKE_CYC = (`SPNV_WAKE_NS + `SPNV_CLK_NS - 1) / `SPNV_CLK_NS,
    parameter logic [55:0] MFR_ID = 56'h5A5A5A5A5A5A3C // Arbitrary value
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_cs_n,
    input wire logic i_sck,
    input wire logic i_si,
    input wire logic i_hold_n,
    input wire logic i_block_protect_hi,
    input wire logic i_block_protect_lo,
    output logic o_so,
    output logic o_so_oe,
    output logic o_write_enable_latch,
    output logic o_sleeping
);
    import spnv_pkg::*;

    logic [5:0] pins;
    logic cs_q;
    logic sck_q;
    spnv_state_t state;
    spnv_state_t next_state;
    spnv_op_t op;
    spnv_op_t next_op;
    logic [2:0] bit_cnt;
    logic [7:0] rx_sr;
    spnv_addr_t addr;
    spnv_addr_t next_addr;
    logic abyte;
    logic next_abyte;
    logic wr_stop;
    logic next_stop;
    logic fetch;
    logic next_fetch;
    logic latch_pend;
    logic next_lpend;
    logic sleep_pend;
    logic next_spend;
    logic [3:0] id_idx;
    logic [3:0] next_idx;
    logic write_enable_latch;
    logic asleep;
    logic [16:0] wake_cnt;
    logic [7:0] tx_byte;
    logic [2:0] tx_cnt;
    logic so_bit;
    logic so_live;
    logic [7:0] mem [`SPNV_WORDS];

    spnv_wr_if wq ();

    spnv_sync #(.N(6)) u_sync (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_d({i_cs_n, i_sck, i_si, i_hold_n, i_block_protect_hi, i_block_protect_lo}),
        .o_q(pins)
    );

    spnv_fifo #(.W($bits(spnv_wr_t)), .D(`SPNV_FIFO_DEPTH)) u_fifo (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .f(wq)
    );

    // Synchronised pins and edge detection
    wire s_cs_n = pins[5];
    wire s_sck = pins[4];
    wire s_si = pins[3];
    wire s_hold_n = pins[2];
    wire [1:0] bp = pins[1:0];
    wire cs_fall = cs_q & ~s_cs_n;
    wire cs_rise = ~cs_q & s_cs_n;
    wire waking = (wake_cnt != 17'h00000);
    wire live = ~s_cs_n & s_hold_n & ~cs_fall;
    wire sck_rise = live & s_sck & ~sck_q;
    wire sck_fall = live & ~s_sck & sck_q;

    // Receive shifter, MSB arrives first
    wire [7:0] rx_byte = {rx_sr[6:0], s_si};
    wire byte_done = sck_rise & (bit_cnt == 3'h7);

    // Opcode decode
    wire op_latch = (rx_byte == `SPNV_OP_SET_LATCH);
    wire op_write = (rx_byte == `SPNV_OP_WRITE);
    wire op_read = (rx_byte == `SPNV_OP_READ);
    wire op_fast = (rx_byte == `SPNV_OP_FAST);
    wire op_sleep = (rx_byte == `SPNV_OP_SLEEP);
    wire op_ident = (rx_byte == `SPNV_OP_IDENT);

    // Protected region from the two protect bits
    wire addr_prot = (bp == 2'h3) |
                     ((bp == 2'h2) & (addr >= `SPNV_PROT_HALF)) |
                     ((bp == 2'h1) & (addr >= `SPNV_PROT_QTR));

    // A byte is taken only whole, only before protection is hit
    wire wr_take = byte_done & (state == ST_WDATA) & ~wr_stop & ~addr_prot;
    wire wr_push = wr_take & wq.in_ready;
    assign wq.in_valid = wr_take;
    assign wq.in_data = '{addr: addr, data: rx_byte};
    // Read fetch owns the single array port; draining waits a cycle
    assign wq.out_ready = ~fetch;
    wire drain = wq.out_valid & wq.out_ready;

    // Identity string, shifted so the current byte sits on top
    wire [15:0] prod_id = {`SPNV_ID_FAMILY, `SPNV_ID_DENSITY, `SPNV_ID_SUB, `SPNV_ID_REV, 3'h0};
    wire [71:0] id_str = {MFR_ID, prod_id};
    wire [71:0] id_sh = id_str << {id_idx, 3'h0};
    wire tx_state = (state == ST_RDATA) | (state == ST_IDENT);

    // Command sequencer
    always_comb begin
        next_state = state;
        next_op = op;
        next_addr = addr;
        next_abyte = abyte;
        next_stop = wr_stop;
        next_fetch = 1'b0;
        next_lpend = latch_pend;
        next_spend = sleep_pend;
        next_idx = id_idx;
        if (cs_fall) begin
            // A sleeping or waking part throws the whole frame away
            next_state = (asleep | waking) ? ST_IGNORE : ST_CMD;
            next_op = OP_NONE;
            next_abyte = 1'b0;
            next_stop = 1'b0;
            next_lpend = 1'b0;
            next_spend = 1'b0;
        end else if (byte_done) begin
            case (state)
                ST_CMD: begin
                    next_state = ST_IGNORE;
                    if (op_latch) begin
                        next_lpend = 1'b1;
                    end
                    if (op_sleep) begin
                        next_spend = 1'b1;
                    end
                    // Write opcode without the latch set is ignored
                    if (op_write & write_enable_latch) begin
                        next_state = ST_ADDR;
                        next_op = OP_WRITE;
                    end
                    if (op_read) begin
                        next_state = ST_ADDR;
                        next_op = OP_READ;
                    end
                    if (op_fast) begin
                        next_state = ST_ADDR;
                        next_op = OP_FAST;
                    end
                    if (op_ident) begin
                        next_state = ST_IDENT;
                        next_idx = 4'h0;
                        next_fetch = 1'b1;
                    end
                end
                ST_ADDR: begin
                    next_abyte = 1'b1;
                    if (!abyte) begin
                        next_addr = {rx_byte[5:0], addr[7:0]};
                    end else begin
                        next_addr = {addr[13:8], rx_byte};
                        if (op == OP_WRITE) begin
                            next_state = ST_WDATA;
                        end else if (op == OP_FAST) begin
                            next_state = ST_DUMMY;
                        end else begin
                            next_state = ST_RDATA;
                            next_fetch = 1'b1;
                        end
                    end
                end
                ST_DUMMY: begin
                    next_state = ST_RDATA;
                    next_fetch = 1'b1;
                end
                ST_WDATA: begin
                    if (wr_push) begin
                        next_addr = addr + 14'h0001;
                    end else if (addr_prot) begin
                        next_stop = 1'b1;
                    end
                end
                ST_RDATA: begin
                    next_addr = addr + 14'h0001;
                    next_fetch = 1'b1;
                end
                ST_IDENT: begin
                    if (id_idx != 4'(`SPNV_ID_BYTES)) begin
                        next_idx = id_idx + 4'h1;
                    end
                    next_fetch = 1'b1;
                end
                default: begin
                end
            endcase
        end
    end

    // Sequencer registers
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state <= ST_IGNORE;
            op <= OP_NONE;
            addr <= '0;
            abyte <= 1'b0;
            wr_stop <= 1'b0;
            fetch <= 1'b0;
            latch_pend <= 1'b0;
            sleep_pend <= 1'b0;
            id_idx <= 4'h0;
        end else begin
            state <= next_state;
            op <= next_op;
            addr <= next_addr;
            abyte <= next_abyte;
            wr_stop <= next_stop;
            fetch <= next_fetch;
            latch_pend <= next_lpend;
            sleep_pend <= next_spend;
            id_idx <= next_idx;
        end
    end

    // Pin history for edges
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cs_q <= 1'b1;
            sck_q <= 1'b1;
        end else begin
            cs_q <= s_cs_n;
            sck_q <= s_sck;
        end
    end

    // Bit counter restarts each frame so a torn byte never completes
    always_ff @(posedge i_clk) begin
        if (i_rst || cs_fall) begin
            bit_cnt <= 3'h0;
            rx_sr <= 8'h00;
        end else if (sck_rise) begin
            bit_cnt <= bit_cnt + 3'h1;
            rx_sr <= rx_byte;
        end
    end

    // Write latch: needs a clean set frame of whole bytes, cleared after any write frame
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            write_enable_latch <= 1'b0;
        end else if (cs_rise) begin
            if (latch_pend && bit_cnt == 3'h0) begin
                write_enable_latch <= 1'b1;
            end else if (op == OP_WRITE) begin
                write_enable_latch <= 1'b0;
            end
        end
    end

    // Sleep and wake recovery
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            asleep <= 1'b0;
            wake_cnt <= 17'h00000;
        end else if (cs_rise && sleep_pend && bit_cnt == 3'h0) begin
            asleep <= 1'b1;
        end else if (cs_fall && asleep) begin
            asleep <= 1'b0;
            wake_cnt <= 17'(WAKE_CYC);
        end else if (waking) begin
            wake_cnt <= wake_cnt - 17'h00001;
        end
    end

    // Array read and identity fetch share one load point
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            tx_byte <= 8'h00;
        end else if (fetch) begin
            tx_byte <= (state == ST_IDENT) ? id_sh[71:64] : mem[addr];
        end
    end

    // Array write from the FIFO, one byte per free cycle
    always_ff @(posedge i_clk) begin
        if (drain) begin
            mem[wq.out_data.addr] <= wq.out_data.data;
        end
    end

    // Output shifter moves on falling serial clock, MSB first
    always_ff @(posedge i_clk) begin
        if (i_rst || cs_fall || cs_rise) begin
            tx_cnt <= 3'h0;
            so_bit <= 1'b0;
            so_live <= 1'b0;
        end else if (sck_fall && tx_state) begin
            tx_cnt <= tx_cnt + 3'h1;
            so_bit <= tx_byte[3'h7 - tx_cnt];
            so_live <= 1'b1;
        end
    end

    // Output floats outside data phases, in hold, asleep and while waking
    assign o_so = so_bit;
    assign o_so_oe = so_live & tx_state & ~s_cs_n & s_hold_n & ~asleep & ~waking;
    assign o_write_enable_latch = write_enable_latch;
    assign o_sleeping = asleep;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    addr_wrap_a: assert property (wr_push |=> addr == 14'($past(addr) + 14'h0001))
        else $error("write address did not advance by one");
    so_float_a: assert property (s_cs_n |=> !so_live && !o_so_oe)
        else $error("output driven with chip select high");
    sleep_float_a: assert property ((asleep || waking) |-> !so_live && !o_so_oe)
        else $error("output driven while asleep or waking");
    latch_clear_a: assert property ((cs_rise && op == OP_WRITE && !latch_pend) |=> !write_enable_latch)
        else $error("write latch survived end of write frame");
    push_whole_a: assert property (wq.in_valid |-> (byte_done && bit_cnt == 3'h7) ##1 bit_cnt == 3'h0)
        else $error("push of an incomplete byte");
    prot_drop_a: assert property ((state == ST_WDATA && wr_stop) |-> !wq.in_valid ##1 addr == $past(addr))
        else $error("byte stored or address moved after protected address");
    hold_pause_a: assert property ((!s_hold_n && !cs_fall) |=> bit_cnt == $past(bit_cnt))
        else $error("bit counter moved during hold");
    ignore_float_a: assert property ((state == ST_IGNORE || state == ST_DUMMY) |-> !so_live && !o_so_oe)
        else $error("output driven in ignored frame");
    sleep_enter_a: assert property ((cs_rise && sleep_pend && bit_cnt == 3'h0) |=> asleep ##1 asleep)
        else $error("sleep not entered after sleep opcode");
    fetch_load_a: assert property (byte_done && state == ST_RDATA |=> fetch ##1 tx_byte === mem[addr])
        else $error("next read byte not fetched");
endmodule

// file: sim/spnv_master.sv
/*
 SPI bus master model, mode 0, standing at the far side of the memory engine.
 Assumes the bench floats the data-out wire whenever the device lets go of it.
*/
module spnv_master (
    output logic o_cs_n,
    output logic o_sck,
    output logic o_si,
    output logic o_hold_n,
    input wire logic i_so
);
    timeunit 1ns;
    timeprecision 10ps;
    localparam real H = 62.5; // Half of the 125 ns link period

    // Idle pins: deselected, clock parked low
    initial begin
        o_cs_n = 1'b1;
        o_sck = 1'b0;
        o_si = 1'b0;
        o_hold_n = 1'b1;
    end

    // Open a frame; the clock stands still outside frames
    task automatic cs_lo();
        o_cs_n = 1'b0;
        #(H);
    endtask

    // Close a frame; si flips so a stale level never passes for data
    task automatic cs_hi();
        #(H);
        o_cs_n = 1'b1;
        o_si = ~o_si;
        #(2 * H);
    endtask

    // Shift n bits MSB first: si moves while sck is low, so is taken on the rise
    task automatic xfer(input logic [7:0] tx, input int n, inout logic [7:0] rx);
        for (int i = 7; i > 7 - n; i--) begin
            o_si = tx[i];
            #(H);
            o_sck = 1'b1;
            rx = {rx[6:0], i_so};
            #(H);
            o_sck = 1'b0;
        end
    endtask

    // Hold changes only well inside the clock's low phase
    task automatic set_hold(input logic v);
        #(H / 2);
        o_hold_n = v;
        #(H);
    endtask
endmodule

// file: sim/tb.sv
/*
 Self-checking bench for the serial memory engine, one task per scenario.
 Assumes the master model drives the link and WAKE_CYC is cut to 20 cycles.
*/
`include "spnv_defs.svh"
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [55:0] MFR = 56'h11223344556677; // Arbitrary value
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic bp_hi = 1'b0;
    logic bp_lo = 1'b0;
    logic cs_n, sck, si, hold_n, so, so_oe, write_enable_latch, sleeping;
    logic [7:0] rx;
    logic [7:0] junk;
    int err_count = 0;
    int check_count = 0;
    wire so_w = so_oe ? so : 1'bz; // Undriven wire floats

    spnv_master m (.o_cs_n(cs_n), .o_sck(sck), .o_si(si), .o_hold_n(hold_n), .i_so(so_w));
    spnv_core #(.WAKE_CYC(20), .MFR_ID(MFR)) DUT (.i_clk(clk), .i_rst(rst), .i_cs_n(cs_n),
        .i_sck(sck), .i_si(si), .i_hold_n(hold_n), .i_block_protect_hi(bp_hi),
        .i_block_protect_lo(bp_lo), .o_so(so), .o_so_oe(so_oe),
        .o_write_enable_latch(write_enable_latch), .o_sleeping(sleeping));

    // 250 MHz clock
    initial begin
        forever #2 clk = ~clk;
    end

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Frame helpers: single opcode, opcode plus address, latched one-byte write
    task automatic cmd(input logic [7:0] op);
        m.cs_lo();
        m.xfer(op, 8, rx);
        m.cs_hi();
    endtask
    task automatic hdr(input logic [7:0] op, input logic [15:0] a);
        m.cs_lo();
        m.xfer(op, 8, rx);
        m.xfer(a[15:8], 8, rx);
        m.xfer(a[7:0], 8, rx);
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        cmd(`SPNV_OP_SET_LATCH);
        hdr(`SPNV_OP_WRITE, a);
        m.xfer(d, 8, rx);
        m.cs_hi();
    endtask

    // Burst across the top address with a cut-off last byte, then read back
    task automatic t_burst();
        logic [7:0] e [4] = '{8'hA5, 8'h3C, 8'h81, 8'h55};
        wr(16'h0001, 8'h55);
        cmd(`SPNV_OP_SET_LATCH);
        chk("latch set", 8'(write_enable_latch), 8'h01);
        hdr(`SPNV_OP_WRITE, 16'hFFFE);
        foreach (e[i]) m.xfer(e[i], i < 3 ? 8 : 4, rx);
        m.cs_hi();
        chk("latch clear", 8'(write_enable_latch), 8'h00);
        hdr(`SPNV_OP_WRITE, 16'h0000);
        m.xfer(8'h00, 8, rx);
        m.cs_hi();
        hdr(`SPNV_OP_READ, 16'hFFFE);
        foreach (e[i]) begin
            m.xfer(8'hC3, 8, rx);
            chk("burst read", rx, e[i]);
        end
        m.xfer(8'hC3, 8, rx); // 0000 holds 81, write without latch refused
        m.cs_hi();
        chk("so float", 8'(so_oe), 8'h00);
    endtask

    // Fast read past the top, noise on si during the data
    task automatic t_fast();
        hdr(`SPNV_OP_FAST, 16'h3FFF);
        m.xfer(8'hFF, 8, rx);
        m.xfer(8'hAA, 8, rx);
        chk("fast 0", rx, 8'h3C);
        m.xfer(8'h55, 8, rx);
        chk("fast 1", rx, 8'h81);
        m.cs_hi();
        chk("fast float", 8'(so_oe), 8'h00);
    endtask

    // Protect settings 1 to 3: byte below the base lands unless the whole array is protected, the base keeps its value
    task automatic t_protect();
        logic [15:0] base [4] = '{16'h0000, 16'h3000, 16'h2000, 16'h0000};
        logic [7:0] old [4] = '{8'h00, 8'h30, 8'h20, 8'h81};
        wr(16'h3000, 8'h30);
        wr(16'h2000, 8'h20);
        for (int k = 1; k < 4; k++) begin
            {bp_hi, bp_lo} = 2'(k);
            wr(base[k] - 16'h0001, 8'(k));
            m.cs_lo();
            m.xfer(`SPNV_OP_WRITE, 0, rx);
            m.cs_hi();
            cmd(`SPNV_OP_SET_LATCH);
            hdr(`SPNV_OP_WRITE, base[k] - 16'h0001);
            m.xfer(8'(k), 8, rx);
            m.xfer(8'hEE, 8, rx);
            m.xfer(8'hDD, 8, rx);
            m.cs_hi();
            {bp_hi, bp_lo} = 2'b00;
            hdr(`SPNV_OP_READ, base[k] - 16'h0001);
            m.xfer(8'h00, 8, rx);
            chk("below base", rx, k < 3 ? 8'(k) : 8'h3C);
            m.xfer(8'h00, 8, rx);
            chk("at base", rx, old[k]);
            m.cs_hi();
        end
    endtask

    // Hold in mid-byte with clocks toggling meanwhile
    task automatic t_hold();
        hdr(`SPNV_OP_READ, 16'h3FFE);
        m.xfer(8'h00, 4, rx);
        m.set_hold(1'b0);
        chk("hold float", 8'(so_oe), 8'h00);
        m.xfer(8'hFF, 3, junk);
        m.set_hold(1'b1);
        m.xfer(8'h00, 4, rx);
        chk("held byte", rx, 8'hA5);
        m.xfer(8'h00, 8, rx);
        chk("after hold", rx, 8'h3C);
        m.cs_hi();
    endtask

    // Nine identity bytes, then one zero byte
    task automatic t_ident();
        logic [79:0] id = {MFR, `SPNV_ID_FAMILY, `SPNV_ID_DENSITY, `SPNV_ID_SUB, `SPNV_ID_REV, 3'b000, 8'h00};
        m.cs_lo();
        m.xfer(`SPNV_OP_IDENT, 8, rx);
        for (int i = 0; i < 10; i++) begin
            m.xfer(8'h00, 8, rx);
            chk("identity", rx, id[79 - 8 * i -: 8]);
        end
        m.cs_hi();
    endtask

    // Sleep, throwaway wake frame, then a real read; unknown opcode stays silent
    task automatic t_sleep();
        cmd(`SPNV_OP_SLEEP);
        chk("asleep", 8'(sleeping), 8'h01);
        chk("sleep float", 8'(so_oe), 8'h00);
        hdr(`SPNV_OP_READ, 16'h3FFE);
        m.xfer(8'h00, 8, rx);
        chk("wake float", 8'(so_oe), 8'h00);
        chk("awake", 8'(sleeping), 8'h00);
        m.cs_hi();
        hdr(`SPNV_OP_READ, 16'h3FFE);
        m.xfer(8'h00, 8, rx);
        m.cs_hi();
        chk("after wake", rx, 8'hA5);
        hdr(8'h05, 16'h0000);
        chk("unknown float", 8'(so_oe), 8'h00);
        m.cs_hi();
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Main sequence: 12-cycle reset, idle outputs, then each scenario
    initial begin
        repeat (12) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        chk("reset oe", 8'(so_oe), 8'h00);
        chk("reset latch", 8'(write_enable_latch), 8'h00);
        chk("reset sleep", 8'(sleeping), 8'h00);
        // Offset keeps every link pin change and check between i_clk edges
        #1.1;
        t_burst();
        $display("burst done");
        t_fast();
        $display("fast read done");
        t_protect();
        $display("protect done");
        t_hold();
        $display("hold done");
        t_ident();
        $display("identity done");
        t_sleep();
        $display("sleep done");
        end_sim();
    end

    // Hang guard: the whole run needs about 130 us, so 300 us means a hang
    initial begin
        #300000;
        err_count++;
        $display("[FAIL] watchdog expected 0 seen 1");
        end_sim();
    end
endmodule
